// ===== design/pcp_core.sv
// Peak current mode pulse-width control core
// Contract
// - Switching period follows one resistor, 100 kHz to 1 MHz.
// - Pulse ends when sensed current exceeds error input divided by six.
// - Slope ramp lowers error level from 40% duty, 98 mV at 80%.
// - Slope ramp is timed from oscillator duty, scaling with frequency.
// - Same slope ramp also applies to the current-limit comparison.
// - Sensed current above 495 mV ends the pulse, cycle by cycle.
// - Overload timer of 30 ms expires into fault, stopping pulses.
// - Overload timer counts up after limit ends, down after modulation or clamp ends.
// - Sensed current above 625 mV ends pulse and bumps short counter.
// - Four consecutive short-circuit trips stop pulses and enter fault.
// - Sense input pulled down while gate low and 60 ns after rise.
// - Short-circuit detector sees current once 60 ns blanking ends.
// - Skip pulses below 300 mV error; resume only above 325 mV.
// - Pulse forced low after 80% of the period.
// - Fault mode holds gate low until fault clears.
// - Short-circuit fault leaves only after auto-recovery timer expires.
`timescale 1ns/1ps
`include "pcp_regs.svh"
`default_nettype none
module pcp_core #(
  parameter int OVERLOAD_FAULT_CYC = `PCP_OVERLOAD_FAULT_CYC,
  parameter int REC_CYC = `PCP_REC_CYC
) (
  input wire logic MCLK_IN,
  input wire logic NRST_IN,
  input wire logic [16:0] FREQ_SET_RESISTOR_PIN_IN,
  input wire logic [9:0] CS_MV_IN,
  input wire logic [11:0] COMP_MV_IN,
  output logic GATE_OUTPUT_OUT,
  output logic CS_PULLDOWN_OUT,
  output logic SKIP_OUT,
  output logic FAULT_OUT,
  output logic OVERLOAD_FAULT_OUT,
  output logic SHORT_CIRCUIT_FAULT_OUT
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    pcp_pkg::pcp_mode_t mode;
    logic gate;
    logic pd;
    logic [3:0] edge_blanking;
    logic skip;
    logic [2:0] scp_cnt;
    logic ovl_up;
    logic [31:0] ovl_cnt;
    logic [31:0] rec_cnt;
  } pcp_core_t;

  pcp_core_t s_ff;
  pcp_core_t nxt_s;

  logic [16:0] rt_ohm;
  logic [9:0] cs_mv;
  logic [11:0] comp_mv;
  logic [16:0] per_raw;
  logic [9:0] period_cyc;
  logic scp_seen;
  logic cs_seen;
  logic [15:0] cs_scaled;
  logic [15:0] cs_limit;
  logic scp_trip;
  logic cl_trip;
  logic pwm_trip;
  logic [2:0] scp_next;

  pcp_osc_if osc_bus ();

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Analog readings arrive asynchronously; two stages each before use
  pcp_sync #(.W(17)) u_sync_rt (
    .clk_in(MCLK_IN),
    .rst_n_in(NRST_IN),
    .d_in(FREQ_SET_RESISTOR_PIN_IN),
    .q_out(rt_ohm)
  );

  pcp_sync #(.W(10)) u_sync_cs (
    .clk_in(MCLK_IN),
    .rst_n_in(NRST_IN),
    .d_in(CS_MV_IN),
    .q_out(cs_mv)
  );

  pcp_sync #(.W(12)) u_sync_comp (
    .clk_in(MCLK_IN),
    .rst_n_in(NRST_IN),
    .d_in(COMP_MV_IN),
    .q_out(comp_mv)
  );

  // ----------------------------------------
  // Oscillator
  // ----------------------------------------
  // Clamp keeps the period inside the supported range even with a bad resistor
  always_comb begin
    per_raw = rt_ohm / 17'(`PCP_OHM_PER_CYC);
    if (per_raw < 17'(`PCP_PER_MIN)) begin
      period_cyc = `PCP_PER_MIN;
    end else if (per_raw > 17'(`PCP_PER_MAX)) begin
      period_cyc = `PCP_PER_MAX;
    end else begin
      period_cyc = per_raw[9:0];
    end
  end

  pcp_osc u_osc (
    .clk_in(MCLK_IN),
    .rst_n_in(NRST_IN),
    .period_cyc_in(period_cyc),
    .osc(osc_bus.osc)
  );

  // ----------------------------------------
  // Blanking and comparators
  // ----------------------------------------
  // Short-circuit path opens first; slower paths wait for ringing to settle
  assign scp_seen = s_ff.gate && (s_ff.edge_blanking >= 4'(`PCP_LEB_SCP_CYC));
  assign cs_seen = s_ff.gate && (s_ff.edge_blanking >= 4'(`PCP_LEB_CS_CYC));
  // Six times cs plus ramp against comp avoids a divider
  assign cs_scaled = (16'(cs_mv) + 16'(osc_bus.slope_mv)) * `PCP_COMP_ATTEN;
  assign cs_limit = 16'(cs_mv) + 16'(osc_bus.slope_mv);
  assign scp_trip = scp_seen && (cs_mv > `PCP_SCP_MV);
  assign cl_trip = cs_seen && (cs_limit > `PCP_CL_MV);
  assign pwm_trip = cs_seen && (cs_scaled > 16'(comp_mv));
  assign scp_next = s_ff.scp_cnt + 3'h1;

  // ----------------------------------------
  // Pulse control and fault handling
  // ----------------------------------------
  // Priority on ends: short circuit, then limit, then modulation and duty clamp
  always_comb begin
    nxt_s = s_ff;
    // Skip hysteresis, evaluated in every mode
    if (comp_mv < `PCP_SKIP_MV) begin
      nxt_s.skip = 1'b1;
    end else if (comp_mv > `PCP_SKIP_MV + `PCP_SKIP_HYS_MV) begin
      nxt_s.skip = 1'b0;
    end
    // Blanking counter saturates so it never wraps into a false window
    if (s_ff.gate && s_ff.edge_blanking != 4'hF) begin
      nxt_s.edge_blanking = s_ff.edge_blanking + 4'h1;
    end
    case (s_ff.mode)
      pcp_pkg::PCP_RUN: begin
        if (s_ff.gate) begin
          if (scp_trip) begin
            nxt_s.gate = 1'b0;
            nxt_s.scp_cnt = scp_next;
            if (scp_next >= `PCP_SCP_TRIPS) begin
              nxt_s.mode = pcp_pkg::PCP_SCP_FAULT;
            end
          end else if (cl_trip) begin
            nxt_s.gate = 1'b0;
            nxt_s.ovl_up = 1'b1;
            nxt_s.scp_cnt = '0;
          end else if (pwm_trip || osc_bus.duty_max_hit) begin
            nxt_s.gate = 1'b0;
            nxt_s.ovl_up = 1'b0;
            nxt_s.scp_cnt = '0;
          end
        end else if (osc_bus.period_start && !nxt_s.skip) begin
          nxt_s.gate = 1'b1;
          nxt_s.edge_blanking = '0;
        end
        // Integrating overload timer: a short overload only partly charges it
        if (s_ff.ovl_up) begin
          if (s_ff.ovl_cnt >= 32'(OVERLOAD_FAULT_CYC - 1)) begin
            nxt_s.mode = pcp_pkg::PCP_OVERLOAD_FAULT_FAULT;
          end else begin
            nxt_s.ovl_cnt = s_ff.ovl_cnt + 32'h1;
          end
        end else if (s_ff.ovl_cnt != '0) begin
          nxt_s.ovl_cnt = s_ff.ovl_cnt - 32'h1;
        end
        if (nxt_s.mode != pcp_pkg::PCP_RUN) begin
          nxt_s.gate = 1'b0;
          nxt_s.rec_cnt = '0;
        end
      end
      default: begin
        // Fault: no switching until the auto-recovery time has run out
        nxt_s.gate = 1'b0;
        if (s_ff.rec_cnt >= 32'(REC_CYC - 1)) begin
          nxt_s.mode = pcp_pkg::PCP_RUN;
          nxt_s.rec_cnt = '0;
          nxt_s.ovl_cnt = '0;
          nxt_s.ovl_up = 1'b0;
          nxt_s.scp_cnt = '0;
        end else begin
          nxt_s.rec_cnt = s_ff.rec_cnt + 32'h1;
        end
      end
    endcase
    // Pull-down follows the next gate state so the pin never lags the driver
    nxt_s.pd = !nxt_s.gate || (nxt_s.edge_blanking < 4'(`PCP_LEB_SCP_CYC));
  end

  // State register
  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      s_ff <= '{mode: pcp_pkg::PCP_RUN, gate: 1'b0, pd: 1'b1, edge_blanking: '0, skip: 1'b1,
                scp_cnt: '0, ovl_up: 1'b0, ovl_cnt: '0, rec_cnt: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign GATE_OUTPUT_OUT = s_ff.gate;
  assign CS_PULLDOWN_OUT = s_ff.pd;
  assign SKIP_OUT = s_ff.skip;
  assign FAULT_OUT = (s_ff.mode != pcp_pkg::PCP_RUN);
  assign OVERLOAD_FAULT_OUT = (s_ff.mode == pcp_pkg::PCP_OVERLOAD_FAULT_FAULT);
  assign SHORT_CIRCUIT_FAULT_OUT = (s_ff.mode == pcp_pkg::PCP_SCP_FAULT);
endmodule
`default_nettype wire

// ===== design/pcp_regs.svh
// Constants of the peak current PWM core: thresholds, timings and clamps
`ifndef PCP_REGS_SVH
`define PCP_REGS_SVH
// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define PCP_CLK_PERIOD_NS 10
`define PCP_LEB_SCP_NS 60
`define PCP_LEB_CS_NS 100
`define PCP_LEB_SCP_CYC ((`PCP_LEB_SCP_NS + `PCP_CLK_PERIOD_NS - 1) / `PCP_CLK_PERIOD_NS)
`define PCP_LEB_CS_CYC ((`PCP_LEB_CS_NS + `PCP_CLK_PERIOD_NS - 1) / `PCP_CLK_PERIOD_NS)
`define PCP_OVERLOAD_FAULT_TIME_MS 30
`define PCP_OVERLOAD_FAULT_CYC (`PCP_OVERLOAD_FAULT_TIME_MS * 1000000 / `PCP_CLK_PERIOD_NS)
`define PCP_REC_TIME_MS 1000
`define PCP_REC_CYC (`PCP_REC_TIME_MS * 1000000 / `PCP_CLK_PERIOD_NS)
// ----------------------------------------
// Oscillator: period cycles = ohms * 100 pF / clock period
// ----------------------------------------
`define PCP_OHM_PER_CYC 100
`define PCP_PER_MIN 10'h064
`define PCP_PER_MAX 10'h3E8
`define PCP_SLOPE_START_PCT 40
`define PCP_DMAX_PCT 80
`define PCP_P40_RST 10'h028
`define PCP_P80_RST 10'h050
// ----------------------------------------
// Analog thresholds in mV, error attenuation factor and short-circuit trip count
// ----------------------------------------
`define PCP_SLOPE_PK_MV 7'h62
`define PCP_COMP_ATTEN 16'h0006
`define PCP_CL_MV 16'h01EF
`define PCP_SCP_MV 10'h271
`define PCP_SKIP_MV 12'h12C
`define PCP_SKIP_HYS_MV 12'h019
`define PCP_SCP_TRIPS 3'h4
`endif

// ===== design/pcp_pkg.sv
// Types shared by the peak current PWM core
package pcp_pkg;
  typedef enum logic [1:0] {
    PCP_RUN,
    PCP_OVERLOAD_FAULT_FAULT,
    PCP_SCP_FAULT
  } pcp_mode_t;
endpackage

// ===== design/pcp_osc_if.sv
// Oscillator timing seen by the pulse control core
`timescale 1ns/1ps
`default_nettype none
interface pcp_osc_if;
  logic period_start;
  logic duty_max_hit;
  logic [6:0] slope_mv;
  modport osc (output period_start, output duty_max_hit, output slope_mv);
  modport core (input period_start, input duty_max_hit, input slope_mv);
endinterface
`default_nettype wire

// ===== design/pcp_sync.sv
// Two flip-flop synchroniser for a bus from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module pcp_sync #(
  parameter int W = 12
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } pcp_sync_t;
  pcp_sync_t s_ff;
  pcp_sync_t nxt_s;

  // Second stage alone reads the first
  always_comb begin
    nxt_s = s_ff;
    nxt_s.meta = d_in;
    nxt_s.q = s_ff.meta;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign q_out = s_ff.q;
endmodule
`default_nettype wire

// ===== design/pcp_osc.sv
// Fixed-frequency oscillator with duty-locked slope ramp
`timescale 1ns/1ps
`include "pcp_regs.svh"
`default_nettype none
module pcp_osc (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [9:0] period_cyc_in,
  pcp_osc_if.osc osc
);
  typedef struct packed {
    logic [9:0] cnt;
    logic [9:0] per;
    logic [9:0] p40;
    logic [9:0] p80;
    logic [6:0] slope;
  } pcp_osc_t;
  pcp_osc_t s_ff;
  pcp_osc_t nxt_s;
  logic [31:0] ramp;

  // ----------------------------------------
  // Period counter and ramp
  // ----------------------------------------
  // New period is latched only at wrap, so a moving resistor never cuts a cycle short
  always_comb begin
    nxt_s = s_ff;
    ramp = '0;
    if (s_ff.cnt >= s_ff.per - 10'h001) begin
      nxt_s.cnt = '0;
      nxt_s.per = period_cyc_in;
      nxt_s.p40 = 10'(32'(period_cyc_in) * `PCP_SLOPE_START_PCT / 100);
      nxt_s.p80 = 10'(32'(period_cyc_in) * `PCP_DMAX_PCT / 100);
    end else begin
      nxt_s.cnt = s_ff.cnt + 10'h001;
    end
    // Ramp tracks duty fraction, so slope scales with frequency
    if (s_ff.cnt > s_ff.p40 && s_ff.p80 > s_ff.p40) begin
      ramp = 32'(`PCP_SLOPE_PK_MV) * 32'(s_ff.cnt - s_ff.p40) / 32'(s_ff.p80 - s_ff.p40);
      nxt_s.slope = (ramp > 32'(`PCP_SLOPE_PK_MV)) ? `PCP_SLOPE_PK_MV : ramp[6:0];
    end else begin
      nxt_s.slope = '0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_ff <= '{cnt: '0, per: `PCP_PER_MIN, p40: `PCP_P40_RST, p80: `PCP_P80_RST,
                slope: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign osc.period_start = (s_ff.cnt == '0);
  assign osc.duty_max_hit = (s_ff.cnt >= s_ff.p80);
  assign osc.slope_mv = s_ff.slope;
endmodule
`default_nettype wire

// ===== verification/pcp_far_end.sv
// Far side model: switch current ramp as it reaches the sense pin
`timescale 1ns/1ps
`default_nettype none
module pcp_far_end (
  input wire logic clk_in,
  input wire logic gate_in,
  input wire logic pulldown_in,
  input wire logic [1:0] mode_in,
  output logic [9:0] cs_mv_out
);
  logic [9:0] ramp_ff;
  // Inductor current grows one mV a cycle while the switch conducts
  always_ff @(posedge clk_in) begin
    ramp_ff <= gate_in ? ramp_ff + 10'h001 : 10'h000;
  end
  // Pull-down wins; mode 1 is a hard short, mode 2 a pulse with no current
  always_comb begin
    if (pulldown_in || !gate_in) cs_mv_out = 10'h000;
    else if (mode_in == 2'h1) cs_mv_out = 10'h2BC;
    else if (mode_in == 2'h2) cs_mv_out = 10'h000;
    else cs_mv_out = ramp_ff;
  end
endmodule
`default_nettype wire

// ===== verification/pcp_core_asserts.sv
// Port level checker of the peak current PWM core
`timescale 1ns/1ps
`default_nettype none
module pcp_core_asserts #(
  parameter int OVERLOAD_FAULT_CYC = 200,
  parameter int REC_CYC = 300
) (
  input wire logic MCLK_IN,
  input wire logic NRST_IN,
  input wire logic GATE_OUTPUT_OUT,
  input wire logic CS_PULLDOWN_OUT,
  input wire logic SKIP_OUT,
  input wire logic FAULT_OUT,
  input wire logic OVERLOAD_FAULT_OUT,
  input wire logic SHORT_CIRCUIT_FAULT_OUT
);
  logic [10:0] hi_ff;
  logic [10:0] gap_ff;
  int flt_ff;
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!NRST_IN);
  // Run lengths: gate high, spacing of rises, time spent in fault
  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      hi_ff <= 11'h000;
      gap_ff <= 11'h7FF;
      flt_ff <= 0;
    end else begin
      hi_ff <= GATE_OUTPUT_OUT ? hi_ff + 11'h001 : 11'h000;
      gap_ff <= $rose(GATE_OUTPUT_OUT) ? 11'h001 : gap_ff + {10'h000, gap_ff != 11'h7FF};
      flt_ff <= FAULT_OUT ? flt_ff + 1 : 0;
    end
  end
  a_rise_when_clear: assert property ($rose(GATE_OUTPUT_OUT) |-> !SKIP_OUT && !FAULT_OUT)
    else $error("gate rose in skip or fault");
  a_fault_gate_low: assert property (FAULT_OUT |-> !GATE_OUTPUT_OUT)
    else $error("gate high in fault");
  a_blank_hold: assert property ($rose(GATE_OUTPUT_OUT) |-> CS_PULLDOWN_OUT [*6] ##1
    (!CS_PULLDOWN_OUT || !GATE_OUTPUT_OUT))
    else $error("sense pull-down blanking length wrong");
  a_pd_gate_low: assert property (!GATE_OUTPUT_OUT |-> CS_PULLDOWN_OUT)
    else $error("pull-down off while gate low");
  // A clamped pulse at the longest period is exactly 800 cycles high
  a_duty_cap: assert property (hi_ff <= 11'h320)
    else $error("pulse longer than duty clamp");
  a_rise_spacing: assert property ($rose(GATE_OUTPUT_OUT) |-> gap_ff >= 11'h064)
    else $error("two pulses closer than shortest period");
  a_fault_recovery: assert property ($fell(FAULT_OUT) |-> flt_ff >= REC_CYC - 1)
    else $error("fault left before recovery time");
  a_fault_kind: assert property (FAULT_OUT == (OVERLOAD_FAULT_OUT || SHORT_CIRCUIT_FAULT_OUT)
    && !(OVERLOAD_FAULT_OUT && SHORT_CIRCUIT_FAULT_OUT))
    else $error("fault outputs disagree");
endmodule
bind pcp_core pcp_core_asserts #(.OVERLOAD_FAULT_CYC(OVERLOAD_FAULT_CYC), .REC_CYC(REC_CYC)) chk (.MCLK_IN,
  .NRST_IN, .GATE_OUTPUT_OUT, .CS_PULLDOWN_OUT, .SKIP_OUT, .FAULT_OUT, .OVERLOAD_FAULT_OUT,
  .SHORT_CIRCUIT_FAULT_OUT);
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench of the peak current PWM core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk = 1'b0;
  logic nrst;
  logic [16:0] res;
  logic [11:0] comp;
  logic [9:0] cs;
  logic [1:0] mode;
  logic gate, pd, skip, flt, ovl, scf;
  logic gate_q = 1'b0;
  int fail_count = 0;
  int comparisons = 0;
  int rises = 0, falls = 0, hi_run = 0, hi_len = 0, since = 0, per_len = 0, cyc = 0;
  always #5 mclk = ~mclk;
  // Short timers keep the overload and recovery runs brief
  pcp_core #(.OVERLOAD_FAULT_CYC(200), .REC_CYC(300)) uut (.MCLK_IN(mclk), .NRST_IN(nrst),
    .FREQ_SET_RESISTOR_PIN_IN(res), .CS_MV_IN(cs), .COMP_MV_IN(comp), .GATE_OUTPUT_OUT(gate),
    .CS_PULLDOWN_OUT(pd), .SKIP_OUT(skip), .FAULT_OUT(flt), .OVERLOAD_FAULT_OUT(ovl),
    .SHORT_CIRCUIT_FAULT_OUT(scf));
  pcp_far_end far (.clk_in(mclk), .gate_in(gate), .pulldown_in(pd), .mode_in(mode),
    .cs_mv_out(cs));
  // Pulse width and period from gate edges; hang guard
  always @(posedge mclk) begin
    cyc++;
    since++;
    if (gate === 1'b1) hi_run++;
    if (gate === 1'b1 && gate_q === 1'b0) begin
      rises++;
      per_len = since;
      since = 0;
    end
    if (gate === 1'b0 && gate_q === 1'b1) begin
      hi_len = hi_run;
      hi_run = 0;
      falls++;
    end
    gate_q = gate;
    if (cyc == 40000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("[ERR] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  // Flag selectors: the flag is read after the wait, not copied at the call
  localparam int F_SKIP = 0;
  localparam int F_OVL = 1;
  localparam int F_FLT = 2;
  localparam int F_SCF = 3;
  // Waits past the edge so registered outputs have settled
  task automatic chk_bit(input int sel, input logic exp);
    logic got;
    #1;
    got = (sel == F_SKIP) ? skip : (sel == F_OVL) ? ovl : (sel == F_FLT) ? flt : scf;
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic start(input logic [16:0] r, input logic [11:0] c, input logic [1:0] m);
    @(posedge mclk) nrst <= 1'b0;
    res <= r;
    comp <= c;
    mode <= m;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    #1 rises = 0;
    falls = 0;
  endtask
  task automatic wait_falls(input int n);
    int t;
    t = falls + n;
    while (falls < t) @(posedge mclk);
  endtask
  // Low error input blanks pulses; 320 mV is inside the hysteresis band
  task automatic t_skip();
    start(17'h186A0, 12'h0C8, 2'h0);
    repeat (2500) @(posedge mclk);
    chk_bit(F_SKIP, 1'b1);
    @(posedge mclk) comp <= 12'h140;
    repeat (2000) @(posedge mclk);
    chk_rng(rises, 0, 0);
    @(posedge mclk) comp <= 12'h190;
    wait_falls(1);
    chk_bit(F_SKIP, 1'b0);
  endtask
  // Modulation, slope, clamp and a shorter period
  task automatic t_width();
    start(17'h186A0, 12'h4B0, 2'h0);
    wait_falls(2);
    chk_rng(hi_len, 200, 210);
    chk_rng(per_len, 1000, 1000);
    @(posedge mclk) comp <= 12'hA8C;
    wait_falls(2);
    chk_rng(hi_len, 436, 448);
    @(posedge mclk) comp <= 12'hFA0;
    mode <= 2'h2;
    wait_falls(2);
    chk_rng(hi_len, 799, 801);
    @(posedge mclk) comp <= 12'h384;
    mode <= 2'h0;
    res <= 17'h04E20;
    wait_falls(3);
    chk_rng(per_len, 200, 200);
    chk_rng(hi_len, 110, 118);
  endtask
  // Limit ends with slope added, then the overload timer trips and recovers
  task automatic t_overload_fault();
    int r;
    start(17'h186A0, 12'hFA0, 2'h0);
    wait_falls(1);
    chk_rng(hi_len, 472, 485);
    chk_bit(F_OVL, 1'b0);
    repeat (250) @(posedge mclk);
    chk_bit(F_OVL, 1'b1);
    r = rises;
    repeat (200) @(posedge mclk);
    chk_bit(F_FLT, 1'b1);
    chk_rng(rises, r, r);
    wait_falls(1);
    chk_bit(F_FLT, 1'b0);
  endtask
  // A clamp-ended pulse between short trips restarts the count
  task automatic t_short();
    start(17'h186A0, 12'hFA0, 2'h1);
    wait_falls(3);
    chk_rng(hi_len, 8, 10);
    @(posedge mclk) mode <= 2'h2;
    wait_falls(1);
    @(posedge mclk) mode <= 2'h1;
    wait_falls(3);
    chk_bit(F_SCF, 1'b0);
    wait_falls(1);
    chk_bit(F_SCF, 1'b1);
    chk_rng(rises, 8, 8);
  endtask
  initial begin
    nrst = 1'b0;
    res = 17'h186A0;
    comp = 12'h000;
    mode = 2'h0;
    t_skip();
    t_width();
    t_overload_fault();
    t_short();
    complete_run();
  end
endmodule
`default_nettype wire
